// file: rtl/bidl_pkg.sv
package bidl_pkg;

  // register bus geometry
  localparam int ADDR_W = 8; // byte address width of the register window
  localparam int DATA_W = 32; // axi4-lite data width
  localparam int STRB_W = DATA_W / 8; // byte lanes

  // register byte offsets
  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00; // control word
  localparam logic [ADDR_W-1:0] CMD_OFS = 8'h04; // command, write-only strobes
  localparam logic [ADDR_W-1:0] STAT_OFS = 8'h08; // live bus and timer state
  localparam logic [ADDR_W-1:0] IF_OFS = 8'h0c; // sticky event flags, write one to clear
  localparam logic [ADDR_W-1:0] IEN_OFS = 8'h10; // event mask, same layout as flags
  localparam logic [ADDR_W-1:0] TMR_OFS = 8'h14; // current idle timer value

  // control word fields
  localparam int CTRL_GI_BIT = 15; // idle_on_timeout_enable
  localparam int CTRL_SEL_LSB = 12; // bus_idle_timeout_select low bit
  localparam int SEL_W = 2; // select field width
  localparam logic CTRL_GI_RST = 1'b0; // go-idle reset value
  localparam logic [SEL_W-1:0] CTRL_SEL_RST = 2'h0; // select reset value

  // command word fields
  localparam int CMD_ABORT_BIT = 0; // disarm the idle timer, bus left busy

  // status word fields
  localparam int STAT_BUSY_BIT = 0; // bus busy from start until stop or go-idle timeout
  localparam int STAT_ACT_BIT = 1; // idle timeout armed
  localparam int STAT_SCL_BIT = 2; // synchronised clock line level

  // event flag layout, shared by flags and mask
  localparam int IF_W = 3; // number of events
  localparam int IF_TO_BIT = 0; // bus idle timeout
  localparam int IF_START_BIT = 1; // start condition seen
  localparam int IF_STOP_BIT = 2; // stop condition seen
  localparam logic [IF_W-1:0] IF_RST = 3'h0; // flags and mask reset value

  // timeout select codes and their counts in prescaled cycles
  localparam logic [SEL_W-1:0] SEL_OFF = 2'h0; // timeout disabled
  localparam logic [SEL_W-1:0] SEL_40 = 2'h1; // 40 prescaled cycles
  localparam logic [SEL_W-1:0] SEL_80 = 2'h2; // 80 prescaled cycles
  localparam logic [SEL_W-1:0] SEL_160 = 2'h3; // 160 prescaled cycles
  localparam int CNT_W = 8; // holds the longest count
  localparam logic [CNT_W-1:0] LIM_40 = 8'h28; // 40
  localparam logic [CNT_W-1:0] LIM_80 = 8'h50; // 80
  localparam logic [CNT_W-1:0] LIM_160 = 8'ha0; // 160

  // axi response codes
  localparam logic [1:0] RESP_OKAY = 2'h0; // access done
  localparam logic [1:0] RESP_DECERR = 2'h3; // no register at that address

endpackage

// file: rtl/bidl_top.sv
`timescale 1ns/10ps
// bus idle timeout block: watches the two-wire bus, tracks busy and times the
// clock line high phase; registers reached over axi4-lite
module bidl_top #(
  parameter int PRESC_DIV = 8 // system clocks per prescaled clock cycle
) (
  input wire logic aclk, // system clock, 50 MHz
  input wire logic aresetn, // synchronous reset, active low
  // axi4-lite write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [bidl_pkg::ADDR_W-1:0] s_axi_awaddr, // write byte address
  input wire logic [2:0] s_axi_awprot, // protection, ignored
  // axi4-lite write data
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  input wire logic [bidl_pkg::DATA_W-1:0] s_axi_wdata, // write data
  input wire logic [bidl_pkg::STRB_W-1:0] s_axi_wstrb, // byte enables
  // axi4-lite write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  output logic [1:0] s_axi_bresp, // write response code
  // axi4-lite read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  input wire logic [bidl_pkg::ADDR_W-1:0] s_axi_araddr, // read byte address
  input wire logic [2:0] s_axi_arprot, // protection, ignored
  // axi4-lite read data
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output logic [bidl_pkg::DATA_W-1:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response code
  // two-wire bus, sensed only
  input wire logic scl_in, // clock line level from the pad
  input wire logic sda_in, // data line level from the pad
  // system side
  output logic bus_busy, // bus held busy from start until stop or go-idle timeout
  output logic idle_timeout, // one-cycle pulse on each idle timeout
  output logic irq // level interrupt, any unmasked flag set
);

  // prescaler counter width, wide enough for PRESC_DIV-1
  localparam int PW = (PRESC_DIV > 1) ? $clog2(PRESC_DIV) : 1;
  localparam logic [PW-1:0] PRESC_LAST = PW'(PRESC_DIV - 1); // wrap value

  // refuse a prescaler the divider cannot serve
  generate
    if (PRESC_DIV < 1) begin : g_bad_presc
      $error("PRESC_DIV must be at least one");
    end
  endgenerate

  // whole state of the block, registered in one place
  typedef struct packed {
    // pad synchronisers and one-cycle history
    logic scl_s1; // first stage, read only by second stage
    logic scl_s2; // clean clock line level
    logic scl_d; // clean level one cycle earlier
    logic sda_s1; // first stage, read only by second stage
    logic sda_s2; // clean data line level
    logic sda_d; // clean level one cycle earlier
    // prescaler and timer
    logic [PW-1:0] presc; // prescaler count
    logic [bidl_pkg::CNT_W-1:0] cnt; // idle timer
    logic busy; // bus busy
    logic act; // idle timeout armed
    logic to_p; // timeout pulse
    // software registers
    logic gi; // idle_on_timeout_enable
    logic [bidl_pkg::SEL_W-1:0] sel; // bus_idle_timeout_select
    logic [bidl_pkg::IF_W-1:0] ifl; // sticky flags
    logic [bidl_pkg::IF_W-1:0] ien; // mask
    logic irq; // registered interrupt
    // axi write side
    logic aw_got; // address held
    logic w_got; // data held
    logic [bidl_pkg::ADDR_W-1:0] waddr; // held write address
    logic [bidl_pkg::DATA_W-1:0] wdata; // held write data
    logic [bidl_pkg::STRB_W-1:0] wstrb; // held byte enables
    logic bvalid; // response pending
    logic [1:0] bresp; // response code
    // axi read side
    logic rvalid; // read data pending
    logic [bidl_pkg::DATA_W-1:0] rdata; // read data
    logic [1:0] rresp; // read response code
  } bidl_state_t;

  bidl_state_t st_r; // current state
  bidl_state_t st_nxt; // next state

  // reset image: constants only
  localparam bidl_state_t ST_RST = '{
    scl_s1: 1'b1, scl_s2: 1'b1, scl_d: 1'b1,
    sda_s1: 1'b1, sda_s2: 1'b1, sda_d: 1'b1,
    presc: '0, cnt: '0, busy: 1'b0, act: 1'b0, to_p: 1'b0,
    gi: bidl_pkg::CTRL_GI_RST, sel: bidl_pkg::CTRL_SEL_RST,
    ifl: bidl_pkg::IF_RST, ien: bidl_pkg::IF_RST, irq: 1'b0,
    aw_got: 1'b0, w_got: 1'b0, waddr: '0, wdata: '0, wstrb: '0,
    bvalid: 1'b0, bresp: bidl_pkg::RESP_OKAY,
    rvalid: 1'b0, rdata: '0, rresp: bidl_pkg::RESP_OKAY
  };

  // count for a select code; off returns zero and is never compared
  function automatic logic [bidl_pkg::CNT_W-1:0] sel_limit(
    input logic [bidl_pkg::SEL_W-1:0] code
  );
    logic [bidl_pkg::CNT_W-1:0] lim;
    lim = '0;
    case (code)
      bidl_pkg::SEL_40: lim = bidl_pkg::LIM_40;
      bidl_pkg::SEL_80: lim = bidl_pkg::LIM_80;
      bidl_pkg::SEL_160: lim = bidl_pkg::LIM_160;
      default: lim = '0; // off
    endcase
    return lim;
  endfunction

  // combinational helpers
  logic tick; // prescaled clock enable
  logic scl_rise; // clock line rose
  logic start_det; // start condition
  logic stop_det; // stop condition
  logic to_evt; // timer hit its count
  logic abort_cmd; // software abort strobe
  logic wr_fire; // write performed this cycle
  logic wr_hit; // write address mapped
  logic [bidl_pkg::IF_W-1:0] if_clr; // flags cleared by software
  logic [bidl_pkg::IF_W-1:0] if_set; // flags raised by hardware
  logic [bidl_pkg::DATA_W-1:0] rd_word; // addressed read word
  logic rd_hit; // read address mapped

  // next-state logic for the whole block
  always_comb begin
    st_nxt = st_r;
    tick = 1'b0;
    to_evt = 1'b0;
    abort_cmd = 1'b0;
    wr_hit = 1'b0;
    if_clr = '0;
    if_set = '0;
    rd_word = '0;
    rd_hit = 1'b0;

    // two flops on each pad before any logic looks at it
    st_nxt.scl_s1 = scl_in;
    st_nxt.scl_s2 = st_r.scl_s1;
    st_nxt.scl_d = st_r.scl_s2;
    st_nxt.sda_s1 = sda_in;
    st_nxt.sda_s2 = st_r.sda_s1;
    st_nxt.sda_d = st_r.sda_s2;

    // bus conditions from clean levels only
    scl_rise = st_r.scl_s2 & ~st_r.scl_d;
    start_det = st_r.scl_s2 & st_r.scl_d & st_r.sda_d & ~st_r.sda_s2;
    stop_det = st_r.scl_s2 & st_r.scl_d & ~st_r.sda_d & st_r.sda_s2;

    // prescaler: one-cycle enable every PRESC_DIV clocks
    if (st_r.presc == PRESC_LAST) begin
      st_nxt.presc = '0;
      tick = 1'b1;
    end else begin
      st_nxt.presc = st_r.presc + PW'(1);
    end

    // write channel capture; address and data in either order
    s_axi_awready = ~st_r.aw_got & ~st_r.bvalid;
    s_axi_wready = ~st_r.w_got & ~st_r.bvalid;
    if (s_axi_awvalid & s_axi_awready) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid & s_axi_wready) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = s_axi_wdata;
      st_nxt.wstrb = s_axi_wstrb;
    end

    // write performed once both halves are held
    wr_fire = st_r.aw_got & st_r.w_got & ~st_r.bvalid;
    if (wr_fire) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      case (st_r.waddr[bidl_pkg::ADDR_W-1:2])
        bidl_pkg::CTRL_OFS[bidl_pkg::ADDR_W-1:2]: begin
          wr_hit = 1'b1;
          // both control fields sit in byte lane one
          if (st_r.wstrb[1]) begin
            st_nxt.gi = st_r.wdata[bidl_pkg::CTRL_GI_BIT];
            st_nxt.sel = st_r.wdata[bidl_pkg::CTRL_SEL_LSB +: bidl_pkg::SEL_W];
          end
        end
        bidl_pkg::CMD_OFS[bidl_pkg::ADDR_W-1:2]: begin
          wr_hit = 1'b1;
          abort_cmd = st_r.wstrb[0] & st_r.wdata[bidl_pkg::CMD_ABORT_BIT];
        end
        bidl_pkg::STAT_OFS[bidl_pkg::ADDR_W-1:2]: begin
          wr_hit = 1'b1; // read-only, write ignored
        end
        bidl_pkg::IF_OFS[bidl_pkg::ADDR_W-1:2]: begin
          wr_hit = 1'b1;
          if (st_r.wstrb[0]) begin
            if_clr = st_r.wdata[bidl_pkg::IF_W-1:0];
          end
        end
        bidl_pkg::IEN_OFS[bidl_pkg::ADDR_W-1:2]: begin
          wr_hit = 1'b1;
          if (st_r.wstrb[0]) begin
            st_nxt.ien = st_r.wdata[bidl_pkg::IF_W-1:0];
          end
        end
        bidl_pkg::TMR_OFS[bidl_pkg::ADDR_W-1:2]: begin
          wr_hit = 1'b1; // read-only, write ignored
        end
        default: wr_hit = 1'b0; // unmapped
      endcase
      st_nxt.bresp = wr_hit ? bidl_pkg::RESP_OKAY : bidl_pkg::RESP_DECERR;
    end
    if (st_r.bvalid & s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end

    // read decode, taken when no answer is pending
    s_axi_arready = ~st_r.rvalid;
    case (s_axi_araddr[bidl_pkg::ADDR_W-1:2])
      bidl_pkg::CTRL_OFS[bidl_pkg::ADDR_W-1:2]: begin
        rd_hit = 1'b1;
        rd_word[bidl_pkg::CTRL_GI_BIT] = st_r.gi;
        rd_word[bidl_pkg::CTRL_SEL_LSB +: bidl_pkg::SEL_W] = st_r.sel;
      end
      bidl_pkg::CMD_OFS[bidl_pkg::ADDR_W-1:2]: begin
        rd_hit = 1'b1; // strobes read as zero
      end
      bidl_pkg::STAT_OFS[bidl_pkg::ADDR_W-1:2]: begin
        rd_hit = 1'b1;
        rd_word[bidl_pkg::STAT_BUSY_BIT] = st_r.busy;
        rd_word[bidl_pkg::STAT_ACT_BIT] = st_r.act;
        rd_word[bidl_pkg::STAT_SCL_BIT] = st_r.scl_s2;
      end
      bidl_pkg::IF_OFS[bidl_pkg::ADDR_W-1:2]: begin
        rd_hit = 1'b1;
        rd_word[bidl_pkg::IF_W-1:0] = st_r.ifl;
      end
      bidl_pkg::IEN_OFS[bidl_pkg::ADDR_W-1:2]: begin
        rd_hit = 1'b1;
        rd_word[bidl_pkg::IF_W-1:0] = st_r.ien;
      end
      bidl_pkg::TMR_OFS[bidl_pkg::ADDR_W-1:2]: begin
        rd_hit = 1'b1;
        rd_word[bidl_pkg::CNT_W-1:0] = st_r.cnt;
      end
      default: rd_hit = 1'b0; // unmapped reads return zero
    endcase
    if (s_axi_arvalid & s_axi_arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = rd_word;
      st_nxt.rresp = rd_hit ? bidl_pkg::RESP_OKAY : bidl_pkg::RESP_DECERR;
    end else if (st_r.rvalid & s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end

    // idle timer: runs only with the clock line high in a transaction;
    // a low clock line is the other timeout's business, so hold at zero
    st_nxt.to_p = 1'b0;
    if (~st_r.act | (st_r.sel == bidl_pkg::SEL_OFF) | ~st_r.scl_s2) begin
      st_nxt.cnt = '0;
    end else if (scl_rise) begin
      st_nxt.cnt = '0;
    end else if (tick) begin
      if (st_r.cnt == sel_limit(st_r.sel) - 8'h01) begin
        to_evt = 1'b1;
        st_nxt.cnt = '0;
      end else begin
        st_nxt.cnt = st_r.cnt + 8'h01;
      end
    end

    // bus state and arming; a late event in the cycle wins over earlier
    if (to_evt) begin
      st_nxt.to_p = 1'b1;
      if (st_r.gi) begin
        st_nxt.busy = 1'b0;
        st_nxt.act = 1'b0;
      end
    end
    if (abort_cmd) begin
      st_nxt.act = 1'b0;
    end
    if (stop_det) begin
      st_nxt.busy = 1'b0;
      st_nxt.act = 1'b0;
    end
    if (start_det) begin
      // repeated start keeps busy; arming follows busy again
      st_nxt.busy = 1'b1;
      st_nxt.act = 1'b1;
    end

    // sticky flags: a hardware set wins over a software clear
    if_set[bidl_pkg::IF_TO_BIT] = to_evt;
    if_set[bidl_pkg::IF_START_BIT] = start_det;
    if_set[bidl_pkg::IF_STOP_BIT] = stop_det;
    st_nxt.ifl = (st_r.ifl & ~if_clr) | if_set;
    st_nxt.irq = |(st_nxt.ifl & st_nxt.ien);
  end

  // single state register, synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from state
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;
  assign bus_busy = st_r.busy;
  assign idle_timeout = st_r.to_p;
  assign irq = st_r.irq;

endmodule

// file: test/bidl_chk.sv
`timescale 1ns/10ps
// port-level watch on the bus handshakes and the idle timeout pulse
module bidl_chk #(
  parameter int PRESC_DIV = 8 // prescaler ratio of the watched block
) (
  input wire logic aclk, // system clock
  input wire logic aresetn, // sync reset, active low
  input wire logic s_axi_awready, // write address ready
  input wire logic s_axi_wready, // write data ready
  input wire logic s_axi_bvalid, // write response valid
  input wire logic s_axi_arready, // read address ready
  input wire logic s_axi_rvalid, // read data valid
  input wire logic scl_in, // clock line pad
  input wire logic sda_in, // data line pad
  input wire logic bus_busy, // busy flag
  input wire logic idle_timeout // timeout pulse
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // a timeout only comes out of a busy bus
  chk_to_needs_busy: assert property (idle_timeout |-> $past(bus_busy))
    else $error("timeout while bus idle");
  // clock line pad sampled high 8 and 40 cycles before every timeout
  chk_to_scl_high: assert property (idle_timeout |-> $past(scl_in, 8) && $past(scl_in, 40))
    else $error("timeout without clock high");
  chk_to_one_cycle: assert property (idle_timeout |=> !idle_timeout)
    else $error("timeout pulse too long");
  // busy leaves only on a stop or a go-idle timeout
  chk_busy_drop: assert property ($fell(bus_busy) |-> idle_timeout || $past(sda_in))
    else $error("busy dropped without cause");
  chk_busy_rise: assert property ($rose(bus_busy) |-> !$past(sda_in) && $past(scl_in))
    else $error("busy rose without start");
  // a fresh arm starts the timer from zero
  chk_arm_fresh: assert property ($rose(bus_busy) |=> !idle_timeout [*8])
    else $error("timeout too soon after arm");
  chk_b_blocks: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted during response");
  chk_r_blocks: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted during response");
endmodule

bind bidl_top bidl_chk #(.PRESC_DIV(PRESC_DIV)) bidl_chk_inst (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .scl_in(scl_in),
  .sda_in(sda_in), .bus_busy(bus_busy), .idle_timeout(idle_timeout));

// file: test/bidl_wire_model.sv
`timescale 1ns/10ps
// other masters on the two-wire bus; lines idle high through pull-ups
module bidl_wire_model (
  input wire logic clk, // pacing clock
  output logic scl, // clock line
  output logic sda // data line
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // start: data falls, clock left high so the timer runs
  task automatic start();
    @(posedge clk) sda <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  // stop: clock low, data low, clock high, data rises
  task automatic stop();
    @(posedge clk) scl <= 1'b0;
    repeat (3) @(posedge clk);
    sda <= 1'b0;
    repeat (3) @(posedge clk);
    scl <= 1'b1;
    repeat (3) @(posedge clk);
    sda <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
  // clock held low for n cycles, then released high
  task automatic low_gap(input int n);
    @(posedge clk) scl <= 1'b0;
    repeat (n) @(posedge clk);
    scl <= 1'b1;
  endtask
endmodule

// file: test/bidl_top_tb.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module bidl_top_tb;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic awready, wready, bvalid, arready, rvalid, bus_busy, idle_timeout, irq, scl, sda;
  logic [1:0] bresp, rresp, r;
  int n_errors = 0;
  int tests_run = 0;
  int n;
  always #10 aclk = ~aclk;
  // prescaler of one: every aclk is a timer tick, periods read directly
  bidl_top #(.PRESC_DIV(1)) bidl_top_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .scl_in(scl), .sda_in(sda), .bus_busy(bus_busy),
    .idle_timeout(idle_timeout), .irq(irq));
  bidl_wire_model bidl_wire_model_inst (.clk(aclk), .scl(scl), .sda(sda));
  // write: ready seen at the negedge equals ready at the next rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic pa, pw, ta, tw, tb;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge aclk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= v;
    bready <= 1'b1;
    while (pa || pw) begin
      @(negedge aclk);
      ta = pa && awready;
      tw = pw && wready;
      @(posedge aclk);
      pa = pa && !ta;
      pw = pw && !tw;
      awvalid <= pa;
      wvalid <= pw;
    end
    do begin
      @(negedge aclk);
      tb = bvalid;
      r = bresp;
      @(posedge aclk);
    end while (!tb);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    logic t;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      t = arready;
      @(posedge aclk);
    end while (!t);
    arvalid <= 1'b0;
    do begin
      @(negedge aclk);
      t = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
    end while (!t);
    rready <= 1'b0;
  endtask
  // cycles until the next timeout pulse, m when none came
  task automatic wt(input int m);
    n = 0;
    while (n < m) begin
      @(negedge aclk);
      if (idle_timeout === 1'b1) break;
      n++;
    end
  endtask
  task automatic t_regs();
    rd(bidl_pkg::CTRL_OFS);
    `CHK("ctrl reset", 32'h0, d)
    wr(bidl_pkg::CTRL_OFS, 32'h8000);
    `CHK("ctrl write resp", 2'h0, r)
    rd(bidl_pkg::CTRL_OFS);
    `CHK("ctrl readback", 32'h8000, d)
    `CHK("ctrl read resp", 2'h0, r)
    wr(8'h40, 32'h0);
    `CHK("unmapped write resp", 2'h3, r)
    rd(8'h40);
    `CHK("unmapped resp", 2'h3, r)
  endtask
  // every select code: off gives no pulse; others period between pulses, busy kept; stop ends it
  task automatic t_sel();
    int lim[4] = '{0, 40, 80, 160};
    for (int k = 0; k < 4; k++) begin
      wr(bidl_pkg::CTRL_OFS, 32'(k) << 12);
      bidl_wire_model_inst.start();
      wt(400);
      if (k > 0) begin
        wt(400);
        `CHK("period", lim[k] - 1, n)
        `CHK("busy kept", 1'b1, bus_busy)
        rd(bidl_pkg::STAT_OFS);
        `CHK("status run", 3'h7, d[2:0])
      end else begin
        `CHK("code off", 400, n)
      end
      bidl_wire_model_inst.stop();
      `CHK("busy after stop", 1'b0, bus_busy)
    end
  endtask
  task automatic t_goidle();
    wr(bidl_pkg::CTRL_OFS, 32'h9000);
    bidl_wire_model_inst.start();
    wt(100);
    `CHK("go idle busy", 1'b0, bus_busy)
    wt(200);
    `CHK("no more timeouts", 200, n)
    bidl_wire_model_inst.stop();
  endtask
  // a low gap on the clock line restarts the count from zero
  task automatic t_restart();
    wr(bidl_pkg::CTRL_OFS, 32'h1000);
    bidl_wire_model_inst.start();
    wt(100);
    repeat (20) @(posedge aclk);
    bidl_wire_model_inst.low_gap(5);
    wt(100);
    `CHK("restart", 1'b1, n > 35 && n < 48)
    bidl_wire_model_inst.stop();
  endtask
  task automatic t_irq();
    // flags left over from earlier scenarios would raise irq on unmasking
    wr(bidl_pkg::IF_OFS, 32'h7);
    wr(bidl_pkg::IEN_OFS, 32'h1);
    @(negedge aclk);
    `CHK("irq idle", 1'b0, irq)
    bidl_wire_model_inst.start();
    wt(100);
    @(negedge aclk);
    `CHK("irq set", 1'b1, irq)
    rd(bidl_pkg::IF_OFS);
    `CHK("timeout flag", 1'b1, d[0])
    wr(bidl_pkg::IEN_OFS, 32'h0);
    @(negedge aclk);
    `CHK("irq masked", 1'b0, irq)
    wr(bidl_pkg::IEN_OFS, 32'h1);
    bidl_wire_model_inst.stop();
    `CHK("irq unmasked", 1'b1, irq)
    wr(bidl_pkg::IF_OFS, 32'h7);
    @(negedge aclk);
    `CHK("irq cleared", 1'b0, irq)
  endtask
  // abort disarms the timer but leaves the bus busy
  task automatic t_abort();
    bidl_wire_model_inst.start();
    wr(bidl_pkg::CMD_OFS, 32'h1);
    wt(100);
    `CHK("abort stops", 100, n)
    rd(bidl_pkg::STAT_OFS);
    `CHK("status abort", 3'h5, d[2:0])
    bidl_wire_model_inst.stop();
  endtask
  task automatic stop_test();
    if (n_errors == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_sel();
    t_goidle();
    t_restart();
    t_irq();
    t_abort();
    stop_test();
  end
  // whole run is under two thousand cycles; this is far beyond it
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    stop_test();
  end
endmodule
